// File: hw/i2csp_consts.svh
`ifndef I2CSP_CONSTS_SVH
`define I2CSP_CONSTS_SVH

// Fixed upper four bits of the seven-bit slave address.
`define I2CSP_ADDR_FIXED 4'h9
// Widest glitch that the line filter rejects, in ns.
`define I2CSP_GLITCH_NS 50
// System clock period in ns.
`define I2CSP_MCLK_NS 8
// Filter length in cycles: a 50 ns glitch is rejected when stable time exceeds it.
`define I2CSP_FILT_CYC ((`I2CSP_GLITCH_NS + `I2CSP_MCLK_NS - 1) / `I2CSP_MCLK_NS)
// Direction bit values in the address byte.
`define I2CSP_DIR_WRITE 1'h0
`define I2CSP_DIR_READ 1'h1

`endif

// File: hw/i2csp_pkg.sv
package i2csp_pkg;
    // Transfer sequencer states.
    typedef enum logic [5:0] {
        I2CSP_IDLE = 6'h01,
        I2CSP_DEVADDR = 6'h02,
        I2CSP_REGHI = 6'h04,
        I2CSP_REGLO = 6'h08,
        I2CSP_WDATA = 6'h10,
        I2CSP_RDATA = 6'h20
    } i2csp_state_t;
endpackage : i2csp_pkg

// File: hw/i2csp_line_filter.sv
`include "i2csp_consts.svh"

// Synchronises one bus line and passes a change only after it has been stable.
module i2csp_line_filter #(
    parameter int FILT_CYC = `I2CSP_FILT_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic line_in,
    output logic line_out
);
    logic sync1;
    logic sync2;
    logic [7:0] stable_cnt;

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1 <= 1'h1;
            sync2 <= 1'h1;
        end
        else
        begin
            sync1 <= line_in;
            sync2 <= sync1;
        end
    end

    // Changes shorter than the filter length are dropped as glitches.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stable_cnt <= 8'h00;
            line_out <= 1'h1;
        end
        else if (sync2 == line_out)
        begin
            stable_cnt <= 8'h00;
        end
        else if (stable_cnt >= 8'(FILT_CYC))
        begin
            line_out <= sync2;
            stable_cnt <= 8'h00;
        end
        else
        begin
            stable_cnt <= stable_cnt + 8'h01;
        end
    end
endmodule : i2csp_line_filter

// File: hw/i2csp_slave.sv
`include "i2csp_consts.svh"

// Behaviour
// - Works with the master clocking at 100 kHz or 400 kHz, never faster.
// - Both line receivers reject pulses shorter than 50 ns.
// - Slave only; the serial clock line is never driven.
// - Registers are selected by a full 16-bit register address.
// - Slave address is fixed 1001 plus three strap bits caught at reset release.
// - Acknowledges and acts only when the received slave address matches.
// - Address byte holds seven address bits MSB first, then direction bit.
// - Write: two register address bytes high first, then unlimited data bytes.
// - Read ends and device idles when master does not acknowledge a byte.
// - Start or stop accepted anywhere; partial bytes are discarded.
module i2csp_slave
    import i2csp_pkg::*;
#(
    parameter int FILT_CYC = `I2CSP_FILT_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] address_strap_pins,
    output logic [15:0] reg_addr,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic rd_strobe,
    input wire logic [7:0] rd_data,
    output logic busy
);
    logic scl_f;
    logic sda_f;
    logic scl_d;
    logic sda_d;
    logic strap_taken;
    logic [2:0] strap;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic ack_phase;
    logic tx_phase;
    logic [7:0] tx_byte;
    logic addr_hit;
    logic [15:0] next_addr;
    i2csp_state_t state;

    wire scl_rise = scl_f && !scl_d;
    wire scl_fall = !scl_f && scl_d;
    wire start_cond = scl_f && scl_d && sda_d && !sda_f;
    wire stop_cond = scl_f && scl_d && !sda_d && sda_f;
    wire [7:0] rx_byte = {shreg[6:0], sda_f};

    // Filtered copies of both lines drive all protocol decisions.
    i2csp_line_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
        .mclk(mclk),
        .arst_n(arst_n),
        .line_in(scl_in),
        .line_out(scl_f)
    );
    i2csp_line_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
        .mclk(mclk),
        .arst_n(arst_n),
        .line_in(sda_in),
        .line_out(sda_f)
    );

    // Previous filtered values for edge and condition detection.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_d <= 1'h1;
            sda_d <= 1'h1;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    // Strap pins are caught once on the first clock after reset release.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_taken <= 1'h0;
            strap <= 3'h0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'h1;
            strap <= address_strap_pins;
        end
    end

    // The clock line is never driven by this device.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_out <= 1'h0;
            scl_oe <= 1'h0;
        end
        else
        begin
            scl_out <= 1'h0;
            scl_oe <= 1'h0;
        end
    end

    // The whole address byte sits in the shift register by the falling clock after its eighth bit.
    assign addr_hit = (shreg[7:1] == {`I2CSP_ADDR_FIXED, strap});

    // Bit sequencer: shifts on rising clock, ends byte and acknowledge on falling clock.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= I2CSP_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            ack_phase <= 1'h0;
            tx_phase <= 1'h0;
            tx_byte <= 8'h00;
            reg_addr <= 16'h0000;
            next_addr <= 16'h0000;
            wr_data <= 8'h00;
            wr_strobe <= 1'h0;
            rd_strobe <= 1'h0;
            sda_out <= 1'h0;
            sda_oe <= 1'h0;
            busy <= 1'h0;
        end
        else
        begin
            wr_strobe <= 1'h0;
            rd_strobe <= 1'h0;
            if (start_cond)
            begin
                state <= I2CSP_DEVADDR;
                bit_cnt <= 4'h0;
                ack_phase <= 1'h0;
                tx_phase <= 1'h0;
                sda_oe <= 1'h0;
                busy <= 1'h1;
            end
            else if (stop_cond)
            begin
                state <= I2CSP_IDLE;
                bit_cnt <= 4'h0;
                ack_phase <= 1'h0;
                tx_phase <= 1'h0;
                sda_oe <= 1'h0;
                busy <= 1'h0;
            end
            else if (state != I2CSP_IDLE && scl_rise)
            begin
                if (ack_phase && tx_phase && sda_f)
                begin
                    state <= I2CSP_IDLE;
                    busy <= 1'h0;
                end
                else if (ack_phase && state == I2CSP_RDATA)
                begin
                    reg_addr <= next_addr; // Address settles so read data is valid at the next fall.
                end
                else if (!ack_phase)
                begin
                    shreg <= rx_byte;
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
            else if (state != I2CSP_IDLE && scl_fall)
            begin
                if (ack_phase)
                begin
                    ack_phase <= 1'h0;
                    bit_cnt <= 4'h0;
                    if (state == I2CSP_RDATA)
                    begin
                        tx_phase <= 1'h1;
                        tx_byte <= {rd_data[6:0], 1'h0};
                        sda_out <= 1'h0;
                        sda_oe <= !rd_data[7];
                        rd_strobe <= 1'h1;
                        next_addr <= next_addr + 16'h0001;
                    end
                    else
                    begin
                        tx_phase <= 1'h0;
                        sda_oe <= 1'h0;
                    end
                end
                else if (tx_phase && bit_cnt != 4'h8)
                begin
                    sda_oe <= !tx_byte[7];
                    tx_byte <= {tx_byte[6:0], 1'h0};
                end
                else if (bit_cnt == 4'h8)
                begin
                    ack_phase <= 1'h1;
                    sda_out <= 1'h0;
                    sda_oe <= !tx_phase;
                    case (state)
                        I2CSP_DEVADDR:
                        begin
                            if (addr_hit)
                            begin
                                state <= (shreg[0] == `I2CSP_DIR_READ) ? I2CSP_RDATA : I2CSP_REGHI;
                            end
                            else
                            begin
                                state <= I2CSP_IDLE;
                                ack_phase <= 1'h0;
                                sda_oe <= 1'h0;
                                busy <= 1'h0;
                            end
                        end
                        I2CSP_REGHI:
                        begin
                            next_addr <= {shreg, next_addr[7:0]};
                            state <= I2CSP_REGLO;
                        end
                        I2CSP_REGLO:
                        begin
                            next_addr <= {next_addr[15:8], shreg};
                            state <= I2CSP_WDATA;
                        end
                        I2CSP_WDATA:
                        begin
                            reg_addr <= next_addr;
                            wr_data <= shreg;
                            wr_strobe <= 1'h1;
                            next_addr <= next_addr + 16'h0001;
                        end
                        I2CSP_RDATA:
                        begin
                            sda_oe <= 1'h0;
                        end
                        default:
                        begin
                            state <= I2CSP_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule : i2csp_slave

// File: verif/i2csp_slave_chk.sv
// Watches the slave's pins and strobes for protocol slips.
module i2csp_slave_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_scl_never_driven: assert property (!scl_oe && !scl_out)
        else $error("scl driven");
    a_sda_pull_low: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    a_idle_released: assert property (!busy |-> !sda_oe)
        else $error("sda held while idle");
    a_write_spacing: assert property (wr_strobe |=> !wr_strobe [*8])
        else $error("write strobes too close");
    a_read_spacing: assert property (rd_strobe |=> !rd_strobe [*8])
        else $error("read strobes too close");
    a_strobe_in_transfer: assert property ((wr_strobe || rd_strobe) |-> busy)
        else $error("strobe outside transfer");
    a_one_strobe: assert property (!(wr_strobe && rd_strobe))
        else $error("read and write together");
    a_reset_quiet: assert property ($rose(arst_n) |-> !busy [*6])
        else $error("busy right after reset");
    a_low_stands: assert property ($rose(sda_oe) |-> sda_oe [*3])
        else $error("sda pull too short");
endmodule : i2csp_slave_chk

bind i2csp_slave i2csp_slave_chk u_chk (.mclk, .arst_n, .scl_out, .scl_oe, .sda_out, .sda_oe,
    .wr_strobe, .rd_strobe, .busy);

// File: verif/i2csp_master_model.sv
// Bus master: makes SCL, sends and reads bytes, frames with start and stop.
module i2csp_master_model (
    input wire logic mclk,
    output logic scl,
    output logic sda,
    input wire logic sda_w
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both lines start released.
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask : w
    // One 80 ns clock pulse, six cycles low and four high; data moves only while SCL is low.
    // The long low phase covers the slave's filter delay, so its SDA change lands no later than the clock edge on which SCL rises.
    task automatic bit_io(input logic b, output logic r);
        w(1);
        sda <= b;
        w(5);
        scl <= 1'h1;
        w(3);
        r = sda_w;
        w(1);
        scl <= 1'h0;
    endtask : bit_io
    // Start, or repeated start when SCL is low; SCL stays low long enough for the slave to let go.
    task automatic start();
        w(1);
        sda <= 1'h1;
        w(5);
        scl <= 1'h1;
        w(5);
        sda <= 1'h0;
        w(5);
        scl <= 1'h0;
    endtask : start
    // Stop, then leave the bus idle a while.
    task automatic stop();
        w(1);
        sda <= 1'h0;
        w(5);
        scl <= 1'h1;
        w(5);
        sda <= 1'h1;
        w(10);
    endtask : stop
    // Sends a byte MSB first and returns the slave's acknowledge.
    task automatic byte_tx(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : byte_tx
    // Reads a byte and answers with acknowledge or not.
    task automatic byte_rx(output logic [7:0] v, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(!ack, r);
    endtask : byte_rx
endmodule : i2csp_master_model

// File: verif/i2c_slave_register_port_bench.sv
// Drives the slave from a master model and checks strobes and answers.
module i2c_slave_register_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] strap = 3'h5;
    logic scl, sda_m, sda_oe, sda_out, scl_out, scl_oe, wr_strobe, rd_strobe, busy;
    logic [15:0] reg_addr;
    logic [7:0] wr_data, rd_data;
    logic [23:0] wq[$];
    logic [15:0] rq[$];
    int bad_count = 0;
    int check_count = 0;
    wire logic sda_w = sda_m & ~sda_oe;
    // Clock, register file stand-in, and logs of writes and read addresses.
    always #4 mclk = ~mclk;
    assign rd_data = reg_addr[7:0] ^ 8'hA5;
    always @(posedge mclk)
        if (wr_strobe) wq.push_back({reg_addr, wr_data});
    always @(posedge mclk)
        if (rd_strobe) rq.push_back(reg_addr);
    i2csp_slave #(.FILT_CYC(2)) dut (.mclk, .arst_n, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda_w),
        .sda_out, .sda_oe, .address_strap_pins(strap), .reg_addr, .wr_data, .wr_strobe, .rd_strobe,
        .rd_data, .busy);
    i2csp_master_model bus (.mclk, .scl, .sda(sda_m), .sda_w);
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Waits a bounded time for the slave to go idle.
    task automatic wait_idle();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge mclk);
        check("idle", busy, 1'h0);
    endtask : wait_idle
    // A short dip of SDA while SCL is high must not open a transfer.
    task automatic t_glitch();
        logic b;
        b = 1'b0;
        bus.sda <= 1'b0;
        repeat (2) @(posedge mclk);
        bus.sda <= 1'b1;
        for (int i = 0; i < 20; i++) @(posedge mclk) b |= busy;
        check("glitch", b, 1'h0);
        $display("glitch test done");
    endtask : t_glitch
    // Register address high then low, then two data bytes.
    task automatic t_write();
        logic a;
        bus.start();
        bus.byte_tx(8'h9A, a);
        check("addr ack", a, 1'h1);
        bus.byte_tx(8'h12, a);
        bus.byte_tx(8'h34, a);
        bus.byte_tx(8'hC3, a);
        bus.byte_tx(8'h3C, a);
        check("data ack", a, 1'h1);
        bus.stop();
        check("writes", 24'(wq.size()), 24'h2);
        check("first", wq[0], 24'h1234C3);
        check("second", wq[1], 24'h12353C);
        wq.delete();
        $display("write test done");
    endtask : t_write
    // Set address, repeated start, read two bytes, refuse the last.
    task automatic t_read();
        logic a;
        logic [7:0] d;
        bus.start();
        bus.byte_tx(8'h9A, a);
        bus.byte_tx(8'h00, a);
        bus.byte_tx(8'h40, a);
        bus.start();
        bus.byte_tx(8'h9B, a);
        check("read ack", a, 1'h1);
        bus.byte_rx(d, 1'b1);
        check("rd0", d, 8'h40 ^ 8'hA5);
        bus.byte_rx(d, 1'b0);
        check("rd1", d, 8'h41 ^ 8'hA5);
        wait_idle();
        bus.stop();
        check("no writes", 24'(wq.size()), 24'h0);
        check("reads", 24'(rq.size()), 24'h2);
        check("rd addr0", 24'(rq[0]), 24'h000040);
        check("rd addr1", 24'(rq[1]), 24'h000041);
        $display("read test done");
    endtask : t_read
    // Another strap address gets no answer and no write.
    task automatic t_miss();
        logic a;
        bus.start();
        bus.byte_tx(8'h98, a);
        check("miss ack", a, 1'h0);
        wait_idle();
        bus.byte_tx(8'h55, a);
        check("miss data", a, 1'h0);
        bus.stop();
        check("miss writes", 24'(wq.size()), 24'h0);
        $display("miss test done");
    endtask : t_miss
    // A stop after five data bits drops the byte.
    task automatic t_partial();
        logic a;
        bus.start();
        bus.byte_tx(8'h9A, a);
        bus.byte_tx(8'h12, a);
        bus.byte_tx(8'h34, a);
        for (int i = 0; i < 5; i++) bus.bit_io(1'b1, a);
        bus.stop();
        wait_idle();
        check("partial", 24'(wq.size()), 24'h0);
        $display("partial test done");
    endtask : t_partial
    // A reset in mid-run catches a new strap value; only the new address answers.
    task automatic t_strap();
        logic a;
        arst_n <= 1'h0;
        strap <= 3'h2;
        repeat (3) @(posedge mclk);
        arst_n <= 1'h1;
        repeat (20) @(posedge mclk);
        check("busy after reset", busy, 1'h0);
        bus.start();
        bus.byte_tx(8'h9A, a);
        check("old strap ack", a, 1'h0);
        bus.start();
        bus.byte_tx(8'h94, a);
        check("new strap ack", a, 1'h1);
        bus.stop();
        wait_idle();
        $display("strap test done");
    endtask : t_strap
    // Main sequence.
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        t_glitch();
        t_write();
        t_read();
        t_miss();
        t_partial();
        t_strap();
        tally_and_finish();
    end
    // Watchdog against a hang.
    initial
    begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end
endmodule : i2c_slave_register_port_bench
